// ---- rtl/sfw_synth_regs.sv ----
// serially loaded frequency word register bank of the synthesizer
`timescale 1ns/100ps
`default_nettype none
module sfw_synth_regs
    import sfw_pkg::*;
#(
    parameter int unsigned NUM_REGS = SFW_NUM_REGS // address slots
)
(
    input wire logic clock, // system clock, 100 MHz
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic ser_clk, // serial shift clock pin
    input wire logic ser_data, // serial data pin
    input wire logic load_en, // load enable pin
    input wire logic vco_in, // oscillator feedback input
    output var sfw_freq_word_t freq_word_q, // decoded frequency word
    output var logic cal_start_q, // calibration start pulse
    output var logic cal_busy_q, // calibration request pending
    output var logic fb_pulse_q, // divided feedback pulse
    output var logic [1:0] mod_sel_q, // prescaler modulus select
    output var logic [SFW_WORD_W-1:0] last_word_q // last accepted word
);
    // reset release chain
    logic rst_meta_q; // first reset stage
    logic rst_sync_n; // released reset

    // pin synchronisers: stage one, stage two, edge history
    logic sclk_s1_q; // serial clock stage one
    logic sclk_s2_q; // serial clock stage two
    logic sclk_s3_q; // serial clock history
    logic sdat_s1_q; // serial data stage one
    logic sdat_s2_q; // serial data stage two, same age as clock stage two
    logic le_s1_q; // load enable stage one
    logic le_s2_q; // load enable stage two
    logic le_s3_q; // load enable history
    logic vco_s1_q; // oscillator stage one
    logic vco_s2_q; // oscillator stage two
    logic vco_s3_q; // oscillator history

    // edge strobes
    logic sclk_rise; // serial clock rising
    logic le_rise; // load enable rising
    logic vco_rise; // oscillator rising

    // frame path
    sfw_frame_t frame; // captured word
    logic frame_valid; // capture strobe
    logic wr_hit; // capture aimed at a real slot

    // register storage, one word per slot
    logic [SFW_WORD_W-1:0] reg_file_q [NUM_REGS]; // stored words
    logic [SFW_WORD_W-1:0] word_low; // slot 0
    logic [SFW_WORD_W-1:0] word_high; // slot 1
    logic [SFW_WORD_W-1:0] word_mod; // slot 3

    // calibration state
    typedef enum logic [1:0] {
        SFW_CAL_IDLE = 2'b01, // no calibration asked
        SFW_CAL_RUN = 2'b10 // calibration asked, awaiting first period
    } sfw_cal_state_t;
    sfw_cal_state_t cal_state_q; // calibration state

    // reset release through two flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    // serial clock synchroniser and edge history
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
        end else begin
            sclk_s1_q <= ser_clk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
        end
    end

    // serial data synchroniser, stage two lines up with the clock edge strobe
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sdat_s1_q <= 1'b0;
            sdat_s2_q <= 1'b0;
        end else begin
            sdat_s1_q <= ser_data;
            sdat_s2_q <= sdat_s1_q;
        end
    end

    // load enable synchroniser and edge history
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            le_s1_q <= 1'b0;
            le_s2_q <= 1'b0;
            le_s3_q <= 1'b0;
        end else begin
            le_s1_q <= load_en;
            le_s2_q <= le_s1_q;
            le_s3_q <= le_s2_q;
        end
    end

    // oscillator synchroniser, input must stay well below 50 MHz
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            vco_s1_q <= 1'b0;
            vco_s2_q <= 1'b0;
            vco_s3_q <= 1'b0;
        end else begin
            vco_s1_q <= vco_in;
            vco_s2_q <= vco_s1_q;
            vco_s3_q <= vco_s2_q;
        end
    end

    // edges seen only past the second stage
    assign sclk_rise = sclk_s2_q && !sclk_s3_q;
    assign le_rise = le_s2_q && !le_s3_q;
    assign vco_rise = vco_s2_q && !vco_s3_q;

    // data sampled as it stood at the edge
    sfw_serial_shift u_shift (
        .clock(clock),
        .rst_sync_n(rst_sync_n),
        .shift_en(sclk_rise),
        .bit_in(sdat_s2_q),
        .load_pulse(le_rise),
        .frame_q(frame),
        .frame_valid_q(frame_valid)
    );

    // only existing slots are written; others drop the word
    assign wr_hit = frame_valid && sfw_addr_mapped(frame.addr);

    // slot storage; fixed bits are kept as sent and steer nothing
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                reg_file_q[i] <= SFW_REG_RESET;
            end
        end else if (wr_hit) begin
            reg_file_q[frame.addr] <= frame;
        end
    end

    // last accepted word for observation
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            last_word_q <= SFW_REG_RESET;
        end else if (wr_hit) begin
            last_word_q <= frame;
        end
    end

    assign word_low = reg_file_q[SFW_REG_FREQ_LOW];
    assign word_high = reg_file_q[SFW_REG_FREQ_HIGH];
    assign word_mod = reg_file_q[SFW_REG_MOD_TEST];

    // frequency word decode from stored slots
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            freq_word_q <= '0;
        end else begin
            freq_word_q.divide_value <= {word_high[SFW_N_HI_MSB:SFW_N_HI_LSB],
                word_low[SFW_N_LO_MSB:SFW_N_LO_LSB]};
            freq_word_q.wide_fraction_select <= word_mod[SFW_WIDE_BIT];
            if (word_mod[SFW_WIDE_BIT]) begin
                // wide: both halves
                freq_word_q.fraction_top_word <= {word_high[SFW_NUM_HI_MSB:SFW_NUM_HI_LSB],
                    word_low[SFW_NUM_LO_MSB:SFW_NUM_LO_LSB]};
            end else begin
                // narrow: upper half ignored
                freq_word_q.fraction_top_word <= {{SFW_FRAC_HI_W{1'b0}},
                    word_low[SFW_NUM_LO_MSB:SFW_NUM_LO_LSB]};
            end
        end
    end

    // calibration start on every slot 0 load
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cal_start_q <= 1'b0;
        end else begin
            cal_start_q <= wr_hit && frame.addr == SFW_REG_FREQ_LOW;
        end
    end

    // calibration pending until the loop gives a divided period
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cal_state_q <= SFW_CAL_IDLE;
            cal_busy_q <= 1'b0;
        end else begin
            case (cal_state_q)
                SFW_CAL_IDLE: begin
                    if (cal_start_q) begin
                        cal_state_q <= SFW_CAL_RUN;
                        cal_busy_q <= 1'b1;
                    end
                end
                SFW_CAL_RUN: begin
                    // a fresh start restarts the wait
                    if (fb_pulse_q && !cal_start_q) begin
                        cal_state_q <= SFW_CAL_IDLE;
                        cal_busy_q <= 1'b0;
                    end
                end
                default: begin
                    cal_state_q <= SFW_CAL_IDLE;
                    cal_busy_q <= 1'b0;
                end
            endcase
        end
    end

    // feedback divider driven by the decoded divide value
    sfw_fb_divider u_div (
        .clock(clock),
        .rst_sync_n(rst_sync_n),
        .vco_tick(vco_rise),
        .divide_value(freq_word_q.divide_value),
        .fb_pulse_q(fb_pulse_q),
        .mod_sel_q(mod_sel_q)
    );

    AST_CAL_ON_LOW_LOAD: assert property (@(posedge clock) disable iff (!rst_sync_n)
        frame_valid && frame.addr == 4'h0 |=> cal_start_q ##1 cal_busy_q)
        else $error("slot 0 load did not start calibration");
    AST_CAL_ONLY_LOW: assert property (@(posedge clock) disable iff (!rst_sync_n)
        $rose(cal_start_q) |-> $past(frame_valid) && $past(frame.addr) == 4'h0)
        else $error("calibration started without slot 0 load");
    AST_FRAC_LOW: assert property (@(posedge clock) disable iff (!rst_sync_n)
        freq_word_q.fraction_top_word[11:0] == $past(word_low[15:4]))
        else $error("fraction low bits not from slot 0");
    AST_FRAC_NARROW: assert property (@(posedge clock) disable iff (!rst_sync_n)
        !freq_word_q.wide_fraction_select |-> freq_word_q.fraction_top_word <= 22'h000fff)
        else $error("narrow fraction exceeds 4095");
    AST_FRAC_WIDE: assert property (@(posedge clock) disable iff (!rst_sync_n)
        freq_word_q.wide_fraction_select
        |-> freq_word_q.fraction_top_word[21:12] == $past(word_high[13:4]))
        else $error("wide fraction high bits not from slot 1");
    AST_WIDE_SOURCE: assert property (@(posedge clock) disable iff (!rst_sync_n)
        ##1 freq_word_q.wide_fraction_select == $past(word_mod[22]))
        else $error("wide select not from slot 3 bit 22");
    AST_DIVIDE_SOURCE: assert property (@(posedge clock) disable iff (!rst_sync_n)
        ##1 freq_word_q.divide_value == $past({word_high[16:14], word_low[23:16]}))
        else $error("divide value not from slots 0 and 1");
    AST_UNMAPPED_DROP: assert property (@(posedge clock) disable iff (!rst_sync_n)
        frame_valid && (frame.addr == 4'ha || frame.addr == 4'hb || frame.addr > 4'hc)
        |=> last_word_q == $past(last_word_q) && !cal_start_q)
        else $error("word to missing slot was accepted");
    AST_SLOT_STORE: assert property (@(posedge clock) disable iff (!rst_sync_n)
        wr_hit |=> last_word_q == $past(frame))
        else $error("accepted word not stored");

    // slot storage follows the captured word
    AST_STORE_LOW: assert property (@(posedge clock) disable iff (!rst_sync_n)
        frame_valid && frame.addr == SFW_REG_FREQ_LOW |=> word_low == $past(frame))
        else $error("slot 0 word not stored as sent");
    AST_STORE_HIGH: assert property (@(posedge clock) disable iff (!rst_sync_n)
        frame_valid && frame.addr == SFW_REG_FREQ_HIGH |=> word_high == $past(frame))
        else $error("slot 1 word not stored as sent");
    AST_STORE_MOD: assert property (@(posedge clock) disable iff (!rst_sync_n)
        frame_valid && frame.addr == SFW_REG_MOD_TEST |=> word_mod == $past(frame))
        else $error("slot 3 word not stored as sent");

    // stored slots and frequency word do not move without an accepted word
    AST_SLOTS_STEADY: assert property (@(posedge clock) disable iff (!rst_sync_n)
        !wr_hit |=> $stable(word_low) && $stable(word_high) && $stable(word_mod))
        else $error("stored slot changed without an accepted word");
    AST_FREQ_STEADY: assert property (@(posedge clock) disable iff (!rst_sync_n)
        $stable(word_low) && $stable(word_high) && $stable(word_mod) |=> $stable(freq_word_q))
        else $error("frequency word changed with steady slots");

    // calibration request lifetime
    AST_CAL_BUSY_HOLD: assert property (@(posedge clock) disable iff (!rst_sync_n)
        cal_busy_q && !fb_pulse_q |=> cal_busy_q)
        else $error("calibration request dropped before a divided period");
    AST_CAL_BUSY_END: assert property (@(posedge clock) disable iff (!rst_sync_n)
        cal_busy_q && fb_pulse_q && !cal_start_q |=> !cal_busy_q)
        else $error("calibration request not ended by divided period");
endmodule // sfw_synth_regs
`default_nettype wire

// ---- rtl/sfw_pkg.sv ----
// shared constants, types and helpers for the frequency word register bank
package sfw_pkg;
    localparam int unsigned SFW_WORD_W = 24; // serial word length
    localparam int unsigned SFW_ADDR_W = 4; // address field width
    localparam int unsigned SFW_DATA_W = 20; // data field width
    localparam int unsigned SFW_NUM_REGS = 13; // address slots 0..12
    localparam int unsigned SFW_DIV_W = 11; // feedback divide width
    localparam int unsigned SFW_FRAC_W = 22; // fraction word width
    localparam int unsigned SFW_FRAC_LO_W = 12; // low fraction part
    localparam int unsigned SFW_FRAC_HI_W = 10; // high fraction part
    localparam int unsigned SFW_C_W = 7; // coarse sub-counter width
    localparam int unsigned SFW_PSC_W = 5; // prescaler count width
    // register slots
    localparam logic [3:0] SFW_REG_FREQ_LOW = 4'h0; // frequency_word_low
    localparam logic [3:0] SFW_REG_FREQ_HIGH = 4'h1; // frequency_word_high_pump
    localparam logic [3:0] SFW_REG_MOD_TEST = 4'h3; // modulator_and_test_pin
    localparam logic [3:0] SFW_REG_LAST_LOW = 4'h9; // fixed_setup_a
    localparam logic [3:0] SFW_REG_FIXED_B = 4'hc; // fixed_setup_b
    // field positions inside the 24-bit word
    localparam int unsigned SFW_N_LO_MSB = 23; // divide low, msb
    localparam int unsigned SFW_N_LO_LSB = 16; // divide low, lsb
    localparam int unsigned SFW_NUM_LO_MSB = 15; // fraction low, msb
    localparam int unsigned SFW_NUM_LO_LSB = 4; // fraction low, lsb
    localparam int unsigned SFW_N_HI_MSB = 16; // divide high, msb
    localparam int unsigned SFW_N_HI_LSB = 14; // divide high, lsb
    localparam int unsigned SFW_NUM_HI_MSB = 13; // fraction high, msb
    localparam int unsigned SFW_NUM_HI_LSB = 4; // fraction high, lsb
    localparam int unsigned SFW_WIDE_BIT = 22; // wide_fraction_select
    // prescaler moduli
    localparam logic [4:0] SFW_PSC_BASE = 5'h10; // divide by 16
    localparam logic [4:0] SFW_PSC_ADD_A = 5'h01; // plus one
    localparam logic [4:0] SFW_PSC_ADD_B = 5'h04; // plus four
    localparam logic [23:0] SFW_REG_RESET = 24'h000000; // register reset
    // one received serial word
    typedef struct packed {
        logic [SFW_DATA_W-1:0] data; // payload bits
        logic [SFW_ADDR_W-1:0] addr; // target slot
    } sfw_frame_t;
    // decoded frequency word
    typedef struct packed {
        logic [SFW_DIV_W-1:0] divide_value; // feedback_divide_value
        logic [SFW_FRAC_W-1:0] fraction_top_word; // effective numerator
        logic wide_fraction_select; // 22-bit fraction mode
    } sfw_freq_word_t;
    // sub-counter split of the divide value
    typedef struct packed {
        logic [SFW_C_W-1:0] c_cnt; // prescaler cycles per period
        logic [1:0] b_cnt; // cycles at plus four
        logic [1:0] a_cnt; // cycles at plus one
    } sfw_split_t;
    // true for slots that exist
    function automatic logic sfw_addr_mapped(input logic [3:0] a);
        return (a <= SFW_REG_LAST_LOW) || (a == SFW_REG_FIXED_B);
    endfunction
    // split divide value into coarse, b and a counts
    function automatic sfw_split_t sfw_split(input logic [SFW_DIV_W-1:0] n);
        return n;
    endfunction
endpackage

// ---- rtl/sfw_serial_shift.sv ----
// serial word shifter and frame capture
`timescale 1ns/100ps
`default_nettype none
module sfw_serial_shift
    import sfw_pkg::*;
(
    input wire logic clock, // system clock
    input wire logic rst_sync_n, // synchronised reset
    input wire logic shift_en, // serial clock rising edge
    input wire logic bit_in, // synchronised serial data
    input wire logic load_pulse, // load enable rising edge
    output var sfw_frame_t frame_q, // captured word
    output var logic frame_valid_q // one-cycle capture strobe
);
    logic [SFW_WORD_W-1:0] shift_q; // msb-first shift chain

    // shift in msb first on each serial clock rising edge
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            shift_q <= SFW_REG_RESET;
        end else if (shift_en) begin
            shift_q <= {shift_q[SFW_WORD_W-2:0], bit_in};
        end
    end

    // take the last 24 bits when load enable rises
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            frame_q <= '0;
            frame_valid_q <= 1'b0;
        end else begin
            frame_valid_q <= load_pulse;
            if (load_pulse) begin
                frame_q <= shift_q;
            end
        end
    end

    AST_FRAME_CAPTURE: assert property (@(posedge clock) disable iff (!rst_sync_n)
        load_pulse && !shift_en |=> frame_valid_q && frame_q == $past(shift_q))
        else $error("captured frame differs from shift chain");
endmodule // sfw_serial_shift
`default_nettype wire

// ---- rtl/sfw_fb_divider.sv ----
// feedback divider: three sub-counters steering a 16/17/20/21 prescaler
`timescale 1ns/100ps
`default_nettype none
module sfw_fb_divider
    import sfw_pkg::*;
(
    input wire logic clock, // system clock
    input wire logic rst_sync_n, // synchronised reset
    input wire logic vco_tick, // one pulse per oscillator cycle
    input wire logic [SFW_DIV_W-1:0] divide_value, // total divide
    output var logic fb_pulse_q, // one pulse per divided period
    output var logic [1:0] mod_sel_q // prescaler modulus, b then a
);
    sfw_split_t split; // c, b, a counts
    logic [SFW_PSC_W-1:0] psc_cnt_q; // prescaler position
    logic [SFW_C_W-1:0] cyc_q; // prescaler cycle in period
    logic [SFW_PSC_W-1:0] modulus; // current prescaler modulus
    logic psc_wrap; // last tick of a prescaler cycle
    logic period_end; // last tick of a full period
    logic [SFW_DIV_W-1:0] ticks_q; // helper tick count
    logic [SFW_DIV_W-1:0] div_prev_q; // helper divide copy
    logic clean_q; // helper: period ran with a steady divide

    assign split = sfw_split(divide_value);

    // modulus: 16, plus one while a runs, plus four while b runs
    always_comb begin
        modulus = SFW_PSC_BASE;
        if (cyc_q < SFW_C_W'(split.a_cnt)) begin
            modulus = modulus + SFW_PSC_ADD_A;
        end
        if (cyc_q < SFW_C_W'(split.b_cnt)) begin
            modulus = modulus + SFW_PSC_ADD_B;
        end
    end

    assign psc_wrap = vco_tick && (psc_cnt_q == modulus - SFW_PSC_W'(1));
    assign period_end = psc_wrap && (cyc_q >= split.c_cnt - SFW_C_W'(1));

    // prescaler and coarse counter
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            psc_cnt_q <= '0;
            cyc_q <= '0;
            fb_pulse_q <= 1'b0;
            mod_sel_q <= 2'h0;
        end else begin
            fb_pulse_q <= period_end;
            mod_sel_q <= {cyc_q < SFW_C_W'(split.b_cnt), cyc_q < SFW_C_W'(split.a_cnt)};
            if (psc_wrap) begin
                psc_cnt_q <= '0;
                cyc_q <= period_end ? '0 : cyc_q + SFW_C_W'(1);
            end else if (vco_tick) begin
                psc_cnt_q <= psc_cnt_q + SFW_PSC_W'(1);
            end
        end
    end

    // helper: ticks in the running period and steadiness of the divide
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ticks_q <= '0;
            div_prev_q <= '0;
            clean_q <= 1'b0;
        end else begin
            div_prev_q <= divide_value;
            if (period_end) begin
                ticks_q <= '0;
                clean_q <= 1'b1;
            end else begin
                if (vco_tick) begin
                    ticks_q <= ticks_q + SFW_DIV_W'(1);
                end
                if (divide_value != div_prev_q) begin
                    clean_q <= 1'b0;
                end
            end
        end
    end

    AST_PERIOD_LENGTH: assert property (@(posedge clock) disable iff (!rst_sync_n)
        period_end && clean_q && divide_value == div_prev_q
        |-> ticks_q + SFW_DIV_W'(1) == divide_value)
        else $error("divided period does not match divide value");
    AST_MODULUS_RANGE: assert property (@(posedge clock) disable iff (!rst_sync_n)
        modulus == 5'h10 || modulus == 5'h11 || modulus == 5'h14 || modulus == 5'h15)
        else $error("prescaler modulus outside 16/17/20/21");
endmodule // sfw_fb_divider
`default_nettype wire

// ---- bench/sfw_host_model.sv ----
// host model that drives the three-wire serial load port
`timescale 1ns/100ps
`default_nettype none
module sfw_host_model (
    input wire logic clock, // system clock
    output logic ser_clk, // shift clock, still low outside frames
    output logic ser_data, // serial data
    output logic load_en // load enable
);
    // hold a level for half of the 160 ns link period
    task automatic half();
        repeat (8) @(posedge clock);
    endtask
    // shift one word msb first, then pulse load enable
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            ser_data <= w[i];
            half();
            ser_clk <= 1'b1;
            half();
            ser_clk <= 1'b0;
        end
        ser_data <= ~w[0]; // released line shows no stale bit
        half();
        load_en <= 1'b1;
        half();
        load_en <= 1'b0;
        half();
    endtask
    // idle levels at time zero
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        load_en = 1'b0;
    end
endmodule // sfw_host_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking testbench for the frequency word register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import sfw_pkg::*;
    // words: N = 11'h537 then 11'h037, numerator 22'h2a5c3f
    localparam logic [23:0] W_HIGH_A = {3'h0, 4'h0, 3'h5, 10'h2a5, 4'h1};
    localparam logic [23:0] W_LOW = {8'h37, 12'hc3f, 4'h0};
    localparam logic [23:0] W_MOD = {1'b0, 1'b1, 18'h0, 4'h3};
    localparam logic [23:0] W_BAD = {20'hfffff, 4'ha};
    localparam logic [23:0] W_HIGH_B = {3'h0, 4'h0, 3'h0, 10'h2a5, 4'h1};
    logic clock = 1'b0; // system clock
    logic rst_n = 1'b0; // reset, active low
    logic vco_in = 1'b0; // oscillator input
    logic vco_on = 1'b0; // oscillator running
    wire logic ser_clk, ser_data, load_en; // serial pins
    sfw_freq_word_t freq_q, e; // seen and expected word
    logic cal_start, cal_busy, fb_pulse; // status outputs
    logic [1:0] mod_sel; // prescaler modulus select
    logic [23:0] last_word; // last accepted word
    int fail_count = 0, tests_run = 0, cal_cnt = 0, vcnt = 0, n, c0, plus4, plus1;
    // 100 MHz clock
    always #5 clock = ~clock;
    // oscillator: one tick every 6 clocks
    always @(posedge clock) begin
        if (vco_on) begin
            vcnt <= (vcnt == 2) ? 0 : vcnt + 1;
            if (vcnt == 2) vco_in <= ~vco_in;
        end
    end
    // count calibration start pulses
    always @(posedge clock) begin
        if (cal_start === 1'b1) cal_cnt <= cal_cnt + 1;
    end
    sfw_host_model host_u (.clock(clock), .ser_clk(ser_clk), .ser_data(ser_data),
        .load_en(load_en));
    sfw_synth_regs dut_u (.clock(clock), .rst_n(rst_n), .ser_clk(ser_clk),
        .ser_data(ser_data), .load_en(load_en), .vco_in(vco_in), .freq_word_q(freq_q),
        .cal_start_q(cal_start), .cal_busy_q(cal_busy), .fb_pulse_q(fb_pulse),
        .mod_sel_q(mod_sel), .last_word_q(last_word));
    // compare and count
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s exp %h seen %h", name, exp, seen);
        end
    endtask
    // send a word and let the bank settle
    task automatic put(input logic [23:0] w);
        host_u.send(w);
        repeat (6) @(posedge clock);
    endtask
    // clocks up to the next feedback pulse, bounded, with modulus tallies
    task automatic gap(output int k, output int m4, output int m1);
        k = 0;
        m4 = 0;
        m1 = 0;
        do begin
            @(negedge clock);
            k++;
            if (mod_sel === 2'b11) m4++;
            if (mod_sel === 2'b01) m1++;
        end while (fb_pulse !== 1'b1 && k < 2000);
    endtask
    // print counts and verdict, then stop
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (30000) @(posedge clock);
        fail_count++;
        close_out();
    end
    // test sequence
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        c0 = cal_cnt;
        // tail of the cold-start order; no regulator slot loaded, no power-up wait owed
        put(W_HIGH_A);
        check("cal after slot1", 64'(cal_cnt - c0), 64'd0);
        // reference divide left at reset, so the numerator is unrestricted
        put(W_LOW);
        check("cal after slot0", 64'(cal_cnt - c0), 64'd1);
        check("cal busy", 64'(cal_busy), 64'd1);
        check("last word", 64'(last_word), 64'(W_LOW));
        e.divide_value = 11'h537;
        e.fraction_top_word = 22'h000c3f;
        e.wide_fraction_select = 1'b0;
        check("narrow word", 64'(freq_q), 64'(e));
        $display("test narrow done");
        put(W_MOD);
        e.fraction_top_word = 22'h2a5c3f;
        e.wide_fraction_select = 1'b1;
        check("wide word", 64'(freq_q), 64'(e));
        put(W_BAD);
        check("unmapped last", 64'(last_word), 64'(W_MOD));
        check("unmapped word", 64'(freq_q), 64'(e));
        $display("test wide done");
        // divide 55 keeps the host clear of the banned low values
        put(W_HIGH_B);
        e.divide_value = 11'h037;
        check("divide word", 64'(freq_q), 64'(e));
        vco_on <= 1'b1;
        gap(n, plus4, plus1);
        gap(n, plus4, plus1);
        check("fb period", 64'(n), 64'd330);
        // 55 is one 21-tick cycle and two 17-tick cycles, 6 clocks a tick
        check("plus four clocks", 64'(plus4), 64'd126);
        check("plus one clocks", 64'(plus1), 64'd204);
        check("cal idle", 64'(cal_busy), 64'd0);
        $display("test divider done");
        // reset in mid-run clears the bank, then a reload works again
        @(posedge clock);
        vco_on <= 1'b0;
        rst_n <= 1'b0;
        repeat (4) @(posedge clock);
        check("reset word", 64'(freq_q), 64'd0);
        check("reset last", 64'(last_word), 64'd0);
        check("reset busy", 64'(cal_busy), 64'd0);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        put(W_LOW);
        e.fraction_top_word = 22'h000c3f;
        e.wide_fraction_select = 1'b0;
        check("reload word", 64'(freq_q), 64'(e));
        check("reload busy", 64'(cal_busy), 64'd1);
        $display("test reset done");
        close_out();
    end
endmodule // tb_top
`default_nettype wire
